// file: pcpm_pkg.sv
// Package of constants for the PCI power state manager.
// Assumes it is compiled before every other file of the block.
//
// What this block does
// RULE1: Wake request low when status and enable set.
// RULE2: Wake request releases when either bit clears.
// RULE3: Status and enable survive PCI bus reset.
// RULE4: Status and enable clear only at power-up.
// RULE5: D1 and D2 behave exactly like D3hot.
// RULE6: Power state is D0 after power-up.
// RULE7: Power state held while PCI power lost. Reset modes 0 and 1 return it to D0 on PCI reset.
// RULE8: Low-power entry sets power-down bit three.
// RULE9: Low power rejects I/O and memory access. The block has no memory port; only I/O accesses are rejected.
// RULE10: Low power blocks bus mastering and interrupts.
// RULE11: Low power scans wake frames, freezes state.
// RULE12: No wake frame scanning in D0.
// RULE13: Wake events detected only in low power.
// RULE14: Wake sources are wake frame and link-down.
// RULE15: Wake frame counts only when enabled.
// RULE16: Wake request stays asserted back in D0.
// RULE17: Transmit clock gated when config bits are 11.
// RULE18: Wake request edges need not follow PCI clock.
// RULE19: Control/status register sits in configuration space.
// RULE20: General control bits pick PCI reset response.
// RULE21: Status bit clears on write of one.
package pcpm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCPM_OFS_GEN_CTRL = 8'h0c;
  localparam logic [7:0] PCPM_OFS_XCVR_CFG = 8'h38;
  localparam logic [7:0] PCPM_OFS_PM_CSR = 8'he0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCPM_CSR_PME_STS = 15;
  localparam int PCPM_CSR_PME_EN = 8;
  localparam int PCPM_CSR_STATE_LO = 0;
  localparam int PCPM_GC_PWR_DOWN = 3;
  localparam int PCPM_GC_CLK_RESTORE = 16;
  localparam int PCPM_GC_IGNORE_RST = 17;
  localparam int PCPM_GC_WAKE_FRAME_EN = 18;
  localparam int PCPM_GC_RST_MODE_LO = 20;
  localparam int PCPM_XC_TX_GATE_LO = 14;

  // ----------------------------------------------------------------
  // Values after reset and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] PCPM_GEN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PCPM_XCVR_CFG_RST = 32'h0000_0000;
  localparam logic [1:0] PCPM_STATE_D0 = 2'h0;
  localparam logic [1:0] PCPM_TX_GATE_ON = 2'h3;
  localparam logic [1:0] PCPM_RST_AT_ASSERT = 2'h0;
  localparam logic [1:0] PCPM_RST_AT_RELEASE = 2'h1;
  localparam logic [23:0] PCPM_CSR_RD_MASK = 24'h00_8103;

  // ----------------------------------------------------------------
  // Power state type
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCPM_D0,
    PCPM_D1,
    PCPM_D2,
    PCPM_D3HOT
  } pcpm_pstate_t;

endpackage

// file: pcpm_sync_if.sv
// Interface between the top module and its pin input synchroniser.
// Assumes both sides run on the one system clock.
`timescale 1ns/10ps
interface pcpm_sync_if;
  logic pci_rst_n;
  logic wake_frame;
  logic link_down;
  logic pci_rst_n_s;
  logic wake_frame_s;
  logic link_down_s;
  modport top (output pci_rst_n, wake_frame, link_down,
               input pci_rst_n_s, wake_frame_s, link_down_s);
  modport sync (input pci_rst_n, wake_frame, link_down,
                output pci_rst_n_s, wake_frame_s, link_down_s);
endinterface

// file: pcpm_pin_sync.sv
// Three-stage synchroniser for the asynchronous pin inputs.
// Assumes the pins change slowly compared to the system clock.
`timescale 1ns/10ps
module pcpm_pin_sync (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Pins in, settled levels out
  pcpm_sync_if.sync sif
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
  } pcpm_sync_st_t;

  pcpm_sync_st_t st_r;
  pcpm_sync_st_t st_nxt;

  // ----------------------------------------------------------------
  // A change counts once the second and third stages agree.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {sif.pci_rst_n, sif.wake_frame, sif.link_down};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 3; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= '{s1: 3'h4, s2: 3'h4, s3: 3'h4, lvl: 3'h4};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.pci_rst_n_s = st_r.lvl[2];
  assign sif.wake_frame_s = st_r.lvl[1];
  assign sif.link_down_s = st_r.lvl[0];

endmodule

// file: pcpm_top.sv
// Power state manager of a PCI network controller.
// Assumes i_reset_n is the power-on reset only; PCI reset is a pin.
`timescale 1ns/10ps
module pcpm_top (
  // Clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Configuration space register port
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_ack,
  // I/O space register port
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_addr,
  input wire logic [31:0] i_io_wdata,
  output logic [31:0] o_io_rdata,
  output logic o_io_ack,
  output logic o_io_reject,
  // Pins from outside
  input wire logic i_pci_rst_n,
  input wire logic i_wake_frame,
  input wire logic i_link_down,
  // Wake request and gating outputs
  output logic o_wake_request_n,
  output logic o_sys_clk_gate,
  output logic o_tx_clk_gate,
  output logic o_wake_scan_en,
  output logic o_bus_master_en,
  output logic o_pci_int_en,
  output logic o_state_hold
);

  typedef struct packed {
    pcpm_pkg::pcpm_pstate_t pstate;
    logic pme_sts;
    logic pme_en;
    logic [31:0] gen_ctrl;
    logic [31:0] xcvr_cfg;
    logic prst_n_d;
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    logic [31:0] io_rdata;
    logic io_ack;
    logic io_reject;
    logic wake_n;
    logic sys_gate;
    logic tx_gate;
    logic scan_en;
    logic bm_en;
    logic int_en;
  } pcpm_st_t;

  pcpm_st_t st_r;
  pcpm_st_t st_nxt;
  pcpm_sync_if sif ();

  assign sif.pci_rst_n = i_pci_rst_n;
  assign sif.wake_frame = i_wake_frame;
  assign sif.link_down = i_link_down;

  pcpm_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .sif(sif)
  );

  logic low_pwr;
  logic wake_evt;
  logic [1:0] rst_mode;
  logic rst_assert_ev;
  logic rst_release_ev;
  logic [23:0] csr_view;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // D1, D2 and D3hot all count as the same low-power mode.
    low_pwr = (st_r.pstate != pcpm_pkg::PCPM_D0); // RULE5
    rst_mode = st_r.gen_ctrl[pcpm_pkg::PCPM_GC_RST_MODE_LO +: 2];
    rst_assert_ev = st_r.prst_n_d & ~sif.pci_rst_n_s;
    rst_release_ev = ~st_r.prst_n_d & sif.pci_rst_n_s;
    // Wake events only while in low power, from either source.
    wake_evt = low_pwr & // RULE13 RULE12
      ((sif.wake_frame_s & st_r.gen_ctrl[pcpm_pkg::PCPM_GC_WAKE_FRAME_EN]) | // RULE15 RULE11
       sif.link_down_s); // RULE14
    csr_view = pcpm_pkg::PCPM_CSR_RD_MASK & {8'h00, st_r.pme_sts, 6'h00, st_r.pme_en,
      6'h00, st_r.pstate};
    st_nxt.prst_n_d = sif.pci_rst_n_s;
    st_nxt.cfg_ack = i_cfg_wr | i_cfg_rd;
    st_nxt.cfg_rdata = 32'h0000_0000;
    st_nxt.io_ack = i_io_wr | i_io_rd;
    st_nxt.io_rdata = 32'h0000_0000;
    st_nxt.io_reject = (i_io_wr | i_io_rd) & low_pwr; // RULE9

    // Configuration space port stays live in every state.
    if (i_cfg_rd && i_cfg_addr == pcpm_pkg::PCPM_OFS_PM_CSR) begin
      st_nxt.cfg_rdata = {8'h00, csr_view}; // RULE19
    end
    if (i_cfg_wr && i_cfg_addr == pcpm_pkg::PCPM_OFS_PM_CSR) begin
      st_nxt.pstate = pcpm_pkg::pcpm_pstate_t'(i_cfg_wdata[pcpm_pkg::PCPM_CSR_STATE_LO +: 2]);
      st_nxt.pme_en = i_cfg_wdata[pcpm_pkg::PCPM_CSR_PME_EN]; // RULE2
      if (i_cfg_wdata[pcpm_pkg::PCPM_CSR_PME_STS]) begin
        st_nxt.pme_sts = 1'b0; // RULE21 RULE2
      end
    end

    // I/O space reaches the control registers only in D0.
    if (!low_pwr) begin
      if (i_io_rd) begin
        if (i_io_addr == pcpm_pkg::PCPM_OFS_GEN_CTRL) begin
          st_nxt.io_rdata = st_r.gen_ctrl;
        end else if (i_io_addr == pcpm_pkg::PCPM_OFS_XCVR_CFG) begin
          st_nxt.io_rdata = st_r.xcvr_cfg;
        end
      end
      if (i_io_wr) begin
        if (i_io_addr == pcpm_pkg::PCPM_OFS_GEN_CTRL) begin
          st_nxt.gen_ctrl = i_io_wdata;
        end else if (i_io_addr == pcpm_pkg::PCPM_OFS_XCVR_CFG) begin
          st_nxt.xcvr_cfg = i_io_wdata;
        end
      end
    end

    // Entering low power sets the power-down bit.
    if (st_nxt.pstate != pcpm_pkg::PCPM_D0 && !low_pwr) begin
      st_nxt.gen_ctrl[pcpm_pkg::PCPM_GC_PWR_DOWN] = 1'b1; // RULE8
    end

    // PCI reset response; the wake bits are never touched here.
    if (!st_r.gen_ctrl[pcpm_pkg::PCPM_GC_IGNORE_RST]) begin
      if ((rst_mode == pcpm_pkg::PCPM_RST_AT_ASSERT && rst_assert_ev) || // RULE20
          (rst_mode == pcpm_pkg::PCPM_RST_AT_RELEASE && rst_release_ev)) begin
        st_nxt.pstate = pcpm_pkg::PCPM_D0; // RULE3 RULE7
        st_nxt.gen_ctrl[pcpm_pkg::PCPM_GC_PWR_DOWN] = 1'b0;
      end
    end

    // A wake event wins over a clear in the same cycle.
    if (wake_evt) begin
      st_nxt.pme_sts = 1'b1;
    end

    // Wake request follows status and enable in every state.
    st_nxt.wake_n = ~(st_nxt.pme_sts & st_nxt.pme_en); // RULE1 RULE16 RULE18
    st_nxt.sys_gate = st_nxt.gen_ctrl[pcpm_pkg::PCPM_GC_PWR_DOWN] &
      ~st_nxt.gen_ctrl[pcpm_pkg::PCPM_GC_CLK_RESTORE]; // RULE8
    st_nxt.tx_gate = (st_nxt.xcvr_cfg[pcpm_pkg::PCPM_XC_TX_GATE_LO +: 2] ==
      pcpm_pkg::PCPM_TX_GATE_ON); // RULE17
    st_nxt.scan_en = (st_nxt.pstate != pcpm_pkg::PCPM_D0); // RULE11 RULE12
    st_nxt.bm_en = (st_nxt.pstate == pcpm_pkg::PCPM_D0); // RULE10
    st_nxt.int_en = (st_nxt.pstate == pcpm_pkg::PCPM_D0); // RULE10
  end

  // ----------------------------------------------------------------
  // State register; the power-on reset is the only clear.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r.pstate <= pcpm_pkg::PCPM_D0; // RULE6
      st_r.pme_sts <= 1'b0; // RULE4
      st_r.pme_en <= 1'b0; // RULE4
      st_r.gen_ctrl <= pcpm_pkg::PCPM_GEN_CTRL_RST;
      st_r.xcvr_cfg <= pcpm_pkg::PCPM_XCVR_CFG_RST;
      st_r.prst_n_d <= 1'b1;
      st_r.cfg_rdata <= 32'h0000_0000;
      st_r.cfg_ack <= 1'b0;
      st_r.io_rdata <= 32'h0000_0000;
      st_r.io_ack <= 1'b0;
      st_r.io_reject <= 1'b0;
      st_r.wake_n <= 1'b1;
      st_r.sys_gate <= 1'b0;
      st_r.tx_gate <= 1'b0;
      st_r.scan_en <= 1'b0;
      st_r.bm_en <= 1'b1;
      st_r.int_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register.
  // ----------------------------------------------------------------
  assign o_cfg_rdata = st_r.cfg_rdata;
  assign o_cfg_ack = st_r.cfg_ack;
  assign o_io_rdata = st_r.io_rdata;
  assign o_io_ack = st_r.io_ack;
  assign o_io_reject = st_r.io_reject;
  assign o_wake_request_n = st_r.wake_n;
  assign o_sys_clk_gate = st_r.sys_gate;
  assign o_tx_clk_gate = st_r.tx_gate;
  assign o_wake_scan_en = st_r.scan_en;
  assign o_bus_master_en = st_r.bm_en;
  assign o_pci_int_en = st_r.int_en;
  assign o_state_hold = st_r.scan_en; // RULE11

endmodule

// file: pcpm_assertions.sv
// Port checker for the power state manager.
// Assumes it is bound to pcpm_top and sees only its ports.
`timescale 1ns/10ps
module pcpm_assertions (
  input wire logic i_clk_sys, i_reset_n, i_cfg_wr, i_cfg_rd, i_io_wr, i_io_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata, o_cfg_rdata, o_io_rdata,
  input wire logic o_cfg_ack, o_io_ack, o_io_reject, o_wake_request_n,
  input wire logic o_wake_scan_en, o_bus_master_en, o_pci_int_en, o_state_hold
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  property p_cfg_ack; o_cfg_ack == $past(i_cfg_wr || i_cfg_rd); endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("cfg ack");
  property p_io_ack; o_io_ack == $past(i_io_wr || i_io_rd); endproperty
  a_io_ack: assert property (p_io_ack) else $error("io ack");
  property p_rej_zero; o_io_reject |-> o_io_ack && o_io_rdata == 32'h0; endproperty
  a_rej_zero: assert property (p_rej_zero) else $error("reject data");
  property p_rej_low;
    o_io_ack && ($past(o_wake_scan_en) == o_wake_scan_en) |-> o_io_reject == o_wake_scan_en;
  endproperty
  a_rej_low: assert property (p_rej_low) else $error("reject state");
  property p_modes;
    o_bus_master_en == !o_wake_scan_en && o_pci_int_en == o_bus_master_en
      && o_state_hold == o_wake_scan_en;
  endproperty
  a_modes: assert property (p_modes) else $error("mode outputs");
  property p_release; i_cfg_wr && i_cfg_addr == 8'he0 && !i_cfg_wdata[8] |=> o_wake_request_n;
  endproperty
  a_release: assert property (p_release) else $error("wake release");
  property p_wake_csr;
    o_cfg_ack && $past(i_cfg_rd) && $past(i_cfg_addr) == 8'he0
      |-> o_wake_request_n == !(o_cfg_rdata[15] && o_cfg_rdata[8]);
  endproperty
  a_wake_csr: assert property (p_wake_csr) else $error("wake level");
  property p_unmapped; o_cfg_ack && $past(i_cfg_addr) != 8'he0 |-> o_cfg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_reset; $rose(i_reset_n) |-> o_bus_master_en && o_wake_request_n; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  c_wake: cover property (!o_wake_request_n);
  c_rej: cover property (o_io_reject);
  c_low: cover property ($rose(o_wake_scan_en));
endmodule

// file: pcpm_host_model.sv
// Host model issuing configuration and I/O space accesses.
// Assumes the target acknowledges one cycle after each strobe.
`timescale 1ns/10ps
module pcpm_host_model (
  input wire logic i_clk_sys,
  output logic o_cfg_wr, o_cfg_rd, o_io_wr, o_io_rd,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata
);
  initial begin
    {o_cfg_wr, o_cfg_rd, o_io_wr, o_io_rd} = 4'h0;
    o_addr = 8'h0;
    o_wdata = 32'h0;
  end
  // Host sets states, enables and clears status here.
  task automatic access(input logic io, wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    {o_cfg_wr, o_cfg_rd, o_io_wr, o_io_rd} <= {!io && wr, !io && !wr, io && wr, io && !wr};
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    {o_cfg_wr, o_cfg_rd, o_io_wr, o_io_rd} <= 4'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
endmodule

// file: test_pcpm_top.sv
// Self-checking bench of the power state manager.
// Assumes the host model makes every register access.
`timescale 1ns/10ps
module test_pcpm_top;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_pci_rst_n = 1'b1;
  logic i_wake_frame = 1'b0, i_link_down = 1'b0;
  logic i_cfg_wr, i_cfg_rd, i_io_wr, i_io_rd, o_cfg_ack, o_io_ack, o_io_reject;
  logic o_wake_request_n, o_sys_clk_gate, o_tx_clk_gate, o_wake_scan_en;
  logic o_bus_master_en, o_pci_int_en, o_state_hold;
  logic [7:0] i_cfg_addr, i_io_addr;
  logic [31:0] i_cfg_wdata, i_io_wdata, o_cfg_rdata, o_io_rdata, r;
  wire [31:0] outs = {27'h0, o_sys_clk_gate, o_wake_scan_en, o_state_hold, o_bus_master_en,
    o_pci_int_en};
  int err_count = 0;
  int total_checks = 0;
  assign i_io_addr = i_cfg_addr;
  assign i_io_wdata = i_cfg_wdata;
  pcpm_host_model host (.i_clk_sys(i_clk_sys), .o_cfg_wr(i_cfg_wr), .o_cfg_rd(i_cfg_rd),
    .o_io_wr(i_io_wr), .o_io_rd(i_io_rd), .o_addr(i_cfg_addr), .o_wdata(i_cfg_wdata));
  pcpm_top dut (.*);
  initial forever #2 i_clk_sys = ~i_clk_sys;
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  task automatic chk_word(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: %h, want %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic chk_pin(input logic got, exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic exp_tx(input logic [31:0] d);
    return d[15:14] == 2'h3;
  endfunction
  function automatic logic [31:0] exp_state(input int m, input logic rel);
    return (m == 0 || (rel && m == 1)) ? 32'h0 : 32'h3;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic power_on();
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    tick(4);
  endtask
  task automatic csr(input logic wr, input logic [31:0] d);
    host.access(1'b0, wr, 8'he0, d);
    chk_pin(o_cfg_ack, 1'b1);
    if (!wr) chk_word(o_cfg_rdata, d);
  endtask
  task automatic io(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic rej);
    host.access(1'b1, wr, a, d);
    chk_pin(o_io_ack, 1'b1);
    chk_pin(o_io_reject, rej);
    if (!wr) chk_word(o_io_rdata, rej ? 32'h0 : d);
  endtask
  task automatic wake_pin(input logic use_frame);
    @(posedge i_clk_sys);
    i_wake_frame <= use_frame;
    i_link_down <= !use_frame;
    tick(8);
    @(posedge i_clk_sys);
    i_wake_frame <= 1'b0;
    i_link_down <= 1'b0;
    tick(6);
  endtask
  task automatic pci_rst(input logic lvl);
    @(posedge i_clk_sys);
    i_pci_rst_n <= lvl;
    tick(6);
  endtask
  initial begin
    void'($urandom(32'h3f11));
    power_on();
    csr(1'b0, 32'h0);
    chk_pin(o_bus_master_en, 1'b1);
    host.access(1'b0, 1'b0, 8'h40, 32'h0);
    chk_word(o_cfg_rdata, 32'h0);
    io(1'b1, 8'h0c, 32'h0004_0000, 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      if (k == 0) r[15:14] = 2'h3;
      io(1'b1, 8'h38, r, 1'b0);
      io(1'b0, 8'h38, r, 1'b0);
      chk_pin(o_tx_clk_gate, exp_tx(r));
    end
    for (int s = 1; s < 4; s++) begin
      csr(1'b1, 32'h100 | s);
      tick(1);
      chk_word(outs, 32'h1c);
      io(1'b0, 8'h0c, 32'h0, 1'b1);
      csr(1'b0, 32'h100 | s);
      csr(1'b1, 32'h100);
      tick(1);
      chk_word(outs, 32'h13);
      io(1'b0, 8'h0c, 32'h0004_0008, 1'b0);
      io(1'b1, 8'h0c, 32'h0004_0000, 1'b0);
    end
    wake_pin(1'b1);
    wake_pin(1'b0);
    csr(1'b0, 32'h100);
    csr(1'b1, 32'h103);
    wake_pin(1'b0);
    chk_pin(o_wake_request_n, 1'b0);
    pci_rst(1'b0);
    csr(1'b0, 32'h8100);
    pci_rst(1'b1);
    chk_pin(o_wake_request_n, 1'b0);
    csr(1'b1, 32'h8100);
    csr(1'b0, 32'h100);
    chk_pin(o_wake_request_n, 1'b1);
    csr(1'b1, 32'h102);
    wake_pin(1'b1);
    csr(1'b1, 32'h2);
    csr(1'b0, 32'h8002);
    chk_pin(o_wake_request_n, 1'b1);
    csr(1'b1, 32'h8000);
    io(1'b1, 8'h0c, 32'h0, 1'b0);
    csr(1'b1, 32'h103);
    wake_pin(1'b1);
    csr(1'b0, 32'h103);
    wake_pin(1'b0);
    csr(1'b0, 32'h8103);
    power_on();
    csr(1'b0, 32'h0);
    for (int m = 0; m < 4; m++) begin
      io(1'b1, 8'h0c, m << 20, 1'b0);
      csr(1'b1, 32'h3);
      pci_rst(1'b0);
      csr(1'b0, exp_state(m, 1'b0));
      pci_rst(1'b1);
      csr(1'b0, exp_state(m, 1'b1));
      csr(1'b1, 32'h0);
    end
    tally_and_finish();
  end
endmodule
bind pcpm_top pcpm_assertions chk (.*);
